// >>> hw/fec_top.sv
/*
  Flash erase control: Wishbone slave with the operation control and
  status registers, mode interlocks, target latch, setup timer, charge
  pump enable and the erase sweep over the cell array.
  Assumes a classic Wishbone master on the same clock.
*/
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
module fec_top
(
  // Clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      resetn_i,
  // Wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [fec_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic [31:0]                    wb_dat_o,
  output logic                           wb_ack_o,
  // Charge pump
  output logic                           pump_en_o
);
  import fec_pkg::*;

  logic            ack_ff;
  logic [31:0]     dat_ff;
  logic            pgm_ff;
  logic            era_ff;
  logic            mass_ff;
  logic            hv_ff;
  logic            latch_ff;
  logic [FA_W-1:0] lat_addr_ff;
  logic [7:0]      setup_ff;
  logic            sweep_ff;
  logic            done_ff;
  logic [FA_W-1:0] sw_addr_ff;

  logic            bus_req;
  logic            is_array;
  logic [FA_W-1:0] bus_fa;
  logic            ctrl_wr;
  logic [7:0]      wd;
  logic            both_req;
  logic            hv_ok;
  logic            nxt_hv;
  logic            arr_wr;
  logic [FA_W-1:0] sw_base;
  logic [FA_W-1:0] sw_last;
  logic            sw_protect;
  logic            sw_we;
  logic            prog_we;
  logic [7:0]      arr_rd;

  assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign is_array = wb_adr_i[ARRAY_BIT];
  assign bus_fa   = wb_adr_i[FA_W+1:2];
  assign ctrl_wr  = bus_req & wb_we_i & ~is_array & (wb_adr_i == OFS_CTRL) & wb_sel_i[0];
  assign arr_wr   = bus_req & wb_we_i & is_array;
  assign wd       = wb_dat_i[7:0];
  assign both_req = wd[CTL_PGM] & wd[CTL_ERA];
  assign hv_ok    = (pgm_ff | era_ff) & latch_ff & (setup_ff == NVS_CNT);
  assign nxt_hv   = wd[CTL_HV] & (hv_ff | hv_ok);

  ////////////////////////////////////////////////////////////////////
  // Wishbone answer, one cycle after the request
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ack_ff <= 1'b0;
    else
      ack_ff <= bus_req;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      dat_ff <= 32'h00000000;
    else if (bus_req & ~wb_we_i)
    begin
      if (is_array)
        dat_ff <= {24'h000000, arr_rd};
      else if (wb_adr_i == OFS_CTRL)
        dat_ff <= {28'h0000000, hv_ff, mass_ff, era_ff, pgm_ff};
      else if (wb_adr_i == OFS_STATUS)
        dat_ff <= {lat_addr_ff, 12'h000, (setup_ff == NVS_CNT), done_ff, sweep_ff,
                   latch_ff};
      else
        dat_ff <= 32'h00000000;
    end
  end

  assign wb_ack_o  = ack_ff;
  assign wb_dat_o  = dat_ff;
  assign pump_en_o = hv_ff;

  ////////////////////////////////////////////////////////////////////
  // Control register
  // Reset clears all bits
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pgm_ff  <= CTRL_RST[CTL_PGM];
      era_ff  <= CTRL_RST[CTL_ERA];
      mass_ff <= CTRL_RST[CTL_MASS];
      hv_ff   <= CTRL_RST[CTL_HV];
    end
    else if (ctrl_wr)
    begin
      if (!both_req)
      begin
        pgm_ff <= wd[CTL_PGM];
        era_ff <= wd[CTL_ERA];
      end
      mass_ff <= wd[CTL_MASS];
      hv_ff   <= nxt_hv;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Target latch on the dummy write, cleared when no mode is selected
  // Only mode clear ends a sequence
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      latch_ff    <= 1'b0;
      lat_addr_ff <= 16'h0000;
    end
    else if (!pgm_ff && !era_ff)
      latch_ff <= 1'b0;
    else if (arr_wr && !latch_ff)
    begin
      latch_ff    <= 1'b1;
      lat_addr_ff <= bus_fa;
    end
  end

  // Setup time from latch to high voltage
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      setup_ff <= 8'h00;
    else if (!latch_ff)
      setup_ff <= 8'h00;
    else if (setup_ff != NVS_CNT)
      setup_ff <= setup_ff + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////
  // Erase sweep
  // Scope from mass bit
  assign sw_base    = mass_ff ? 16'h0000 : {lat_addr_ff[FA_W-1:PAGE_BITS], 9'h000};
  assign sw_last    = mass_ff ? FA_TOP : {lat_addr_ff[FA_W-1:PAGE_BITS], 9'h1ff};
  assign sw_protect = ~mass_ff & (sw_addr_ff >= OPTION_ADDR);
  assign sw_we      = sweep_ff & hv_ff & era_ff & ~sw_protect;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sweep_ff   <= 1'b0;
      done_ff    <= 1'b0;
      sw_addr_ff <= 16'h0000;
    end
    else if (!latch_ff)
    begin
      sweep_ff <= 1'b0;
      done_ff  <= 1'b0;
    end
    else if (!(hv_ff && era_ff))
      sweep_ff <= 1'b0;
    else if (!sweep_ff && !done_ff)
    begin
      sweep_ff   <= 1'b1;
      sw_addr_ff <= sw_base;
    end
    else if (sweep_ff)
    begin
      if (sw_addr_ff == sw_last)
      begin
        sweep_ff <= 1'b0;
        done_ff  <= 1'b1;
      end
      else
        sw_addr_ff <= sw_addr_ff + 16'h0001;
    end
  end

  // Program clears bits only under high voltage
  assign prog_we = arr_wr & pgm_ff & hv_ff & latch_ff;

  ////////////////////////////////////////////////////////////////////
  // Cell array
  // Erase writes ones, program clears bits
  fec_array u_array
  (
    .ref_clk_i  (ref_clk_i),
    .rd_addr_i  (bus_fa),
    .rd_data_o  (arr_rd),
    .wr_en_i    (sw_we | prog_we),
    .wr_erase_i (sw_we),
    .wr_addr_i  (sw_we ? sw_addr_ff : bus_fa),
    .wr_data_i  (wd)
  );

  ////////////////////////////////////////////////////////////////////
  // Checks
  mode_interlock_a: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i) !(pgm_ff && era_ff))
    else $error("program and erase both set");

  both_refused_a: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    ctrl_wr && both_req |=> $stable(pgm_ff) && $stable(era_ff))
    else $error("write of both modes changed mode bits");

  hv_gate_a: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    $rose(hv_ff) |-> $past(pgm_ff | era_ff) && $past(latch_ff)
                     && ($past(setup_ff) == NVS_CNT))
    else $error("high voltage set out of sequence");

  pump_follow_a: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    ctrl_wr && !wd[CTL_HV] |=> !pump_en_o)
    else $error("pump stayed on after clear");

  page_bound_a: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    sw_we && !mass_ff |-> sw_addr_ff[FA_W-1:PAGE_BITS] == lat_addr_ff[FA_W-1:PAGE_BITS])
    else $error("page erase left its page");

  vector_keep_a: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    sw_we && !mass_ff |-> sw_addr_ff < OPTION_ADDR)
    else $error("page erase hit protected top");

  page_time_a: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    $rose(sweep_ff) && !mass_ff ##1 (hv_ff && era_ff)[*8] |-> ##[500:512] done_ff)
    else $error("page sweep length wrong");

  latch_clear_a: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    !pgm_ff && !era_ff |=> !latch_ff)
    else $error("latch kept without mode");

  bus_ack_a: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

endmodule // fec_top

// >>> pkg/fec_pkg.sv
/*
  Constants for the flash erase control block: register map, control
  field positions, array decode and sequence timing.
  Assumes a 50 MHz bus clock and a 64 KiB byte-addressed array.
*/
package fec_pkg;

  ////////////////////////////////////////////////////////////////////
  // Bus and array geometry
  localparam int unsigned ADR_W        = 19;
  localparam int unsigned FA_W         = 16;
  localparam int unsigned ARRAY_BIT    = 18;
  localparam int unsigned PAGE_BITS    = 9;
  localparam int unsigned ARRAY_BYTES  = 65536;
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;

  ////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses, register region)
  localparam logic [ADR_W-1:0] OFS_CTRL   = 19'h00000;
  localparam logic [ADR_W-1:0] OFS_STATUS = 19'h00004;

  // Control field positions
  localparam int unsigned CTL_PGM  = 0;
  localparam int unsigned CTL_ERA  = 1;
  localparam int unsigned CTL_MASS = 2;
  localparam int unsigned CTL_HV   = 3;
  localparam logic [7:0]  CTRL_RST = 8'h00;

  // Status field positions
  localparam int unsigned ST_LATCH = 0;
  localparam int unsigned ST_SWEEP = 1;
  localparam int unsigned ST_DONE  = 2;
  localparam int unsigned ST_SETUP = 3;
  localparam int unsigned ST_ADDR  = 16;

  ////////////////////////////////////////////////////////////////////
  // Protected decode: option byte then vector block at the top
  localparam logic [FA_W-1:0] OPTION_ADDR = 16'hffcf;
  localparam logic [FA_W-1:0] VECTOR_BASE = 16'hffd0;
  localparam logic [FA_W-1:0] FA_TOP      = 16'hffff;

  ////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned NVS_NS        = 5000;
  localparam int unsigned NVS_CYC       = (NVS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  NVS_CNT       = 8'(NVS_CYC);

endpackage

// >>> hw/fec_array.sv
/*
  Byte-wide flash cell array: asynchronous read port, one write port
  that either erases a byte to all ones or programs by clearing bits.
  Assumes the caller orders erase and program writes.
*/
`timescale 1ns/100ps
module fec_array
(
  // Clock
  input  wire logic                     ref_clk_i,
  // Read port
  input  wire logic [fec_pkg::FA_W-1:0] rd_addr_i,
  output logic [7:0]                    rd_data_o,
  // Write port
  input  wire logic                     wr_en_i,
  input  wire logic                     wr_erase_i,
  input  wire logic [fec_pkg::FA_W-1:0] wr_addr_i,
  input  wire logic [7:0]               wr_data_i
);
  import fec_pkg::*;

  logic [7:0] cell_mem [ARRAY_BYTES];

  assign rd_data_o = cell_mem[rd_addr_i];

  ////////////////////////////////////////////////////////////////////
  // Erase sets ones, program can only clear bits
  always_ff @(posedge ref_clk_i)
  begin
    if (wr_en_i)
    begin
      if (wr_erase_i)
        cell_mem[wr_addr_i] <= ERASED_BYTE;
      else
        cell_mem[wr_addr_i] <= cell_mem[wr_addr_i] & wr_data_i;
    end
  end

endmodule // fec_array

// >>> test/tb_fec_top.sv
/*
  Bench for the flash erase control block. It covers register interlocks,
  mass erase, programming and page erase over Wishbone.
  Assumes a one-cycle registered ack and the 250-cycle setup timer.
*/
`timescale 1ns/100ps
module tb_fec_top;
  import fec_pkg::*;

  logic             ref_clk;
  logic             resetn;
  logic             wb_cyc;
  logic             wb_stb;
  logic             wb_we;
  logic [ADR_W-1:0] wb_adr;
  logic [3:0]       wb_sel;
  logic [31:0]      wb_dat;
  logic [31:0]      wb_rdat;
  logic             wb_ack;
  logic             pump_en;
  logic [31:0]      rv;
  int               miscompares;
  int               checks_done;
  logic [FA_W-1:0]  pa [6] = '{16'h1200, 16'hfdff, 16'hfe05, 16'hffcf, 16'hffd0, 16'hfe00};
  logic [7:0]       pe [6] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff};

  fec_top uut
  (
    .ref_clk_i (ref_clk),
    .resetn_i  (resetn),
    .wb_cyc_i  (wb_cyc),
    .wb_stb_i  (wb_stb),
    .wb_we_i   (wb_we),
    .wb_adr_i  (wb_adr),
    .wb_sel_i  (wb_sel),
    .wb_dat_i  (wb_dat),
    .wb_dat_o  (wb_rdat),
    .wb_ack_o  (wb_ack),
    .pump_en_o (pump_en)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic cycle, held until ack is sampled
  task automatic xfer(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] dat,
                      output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    if (wb_ack !== 1'b1)
    begin
      miscompares++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [ADR_W-1:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, dat, rv);
  endtask

  task automatic rd(input logic [ADR_W-1:0] adr, output logic [31:0] q);
    xfer(1'b0, adr, 32'h0, q);
  endtask

  task automatic ctl(input logic [7:0] d);
    wr(OFS_CTRL, {24'h0, d});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  function automatic logic [ADR_W-1:0] fa(input logic [FA_W-1:0] a);
    return {1'b1, a, 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Erase time is cut short by polling the sweep done flag
  task automatic erase(input logic mass, input logic [FA_W-1:0] a);
    logic [7:0] m;
    int         n;
    m = {5'h0, mass, 2'b10};
    n = 0;
    ctl(m);
    wr(fa(a), 32'h0000005a);
    rd(OFS_STATUS, rv);
    check("latch", rv & 32'hffff0009, {a, 16'h0001});
    ctl(m | 8'h08);
    rd(OFS_CTRL, rv);
    check("hv early", rv, {24'h0, m});
    idle(NVS_CYC + 10);
    rd(OFS_STATUS, rv);
    check("setup elapsed", rv & 32'h0000000f, 32'h00000009);
    ctl(m | 8'h08);
    rd(OFS_CTRL, rv);
    check("hv set", rv, {24'h0, m | 8'h08});
    check("pump on", {31'h0, pump_en}, 32'h1);
    rd(19'h00010, rv);
    check("unmapped", rv, 32'h0);
    rd(OFS_STATUS, rv);
    check("sweeping", rv & 32'h00000006, 32'h00000002);
    do
    begin
      rd(OFS_STATUS, rv);
      n++;
    end while (rv[ST_DONE] !== 1'b1 && n < 22500);
    check("done", {31'h0, rv[ST_DONE]}, 32'h1);
    ctl({5'h1, mass, 2'b00});
    check("pump held", {31'h0, pump_en}, 32'h1);
    idle(mass ? 5000 : 250);
    ctl(8'h00);
    check("pump off", {31'h0, pump_en}, 32'h0);
    idle(50);
  endtask

  task automatic program_all();
    ctl(8'h01);
    wr(fa(pa[0]), 32'h0);
    idle(NVS_CYC + 10);
    ctl(8'h09);
    foreach (pa[i])
      wr(fa(pa[i]), 32'h0);
    wr(fa(16'h1201), 32'h000000a5);
    ctl(8'h08);
    idle(250);
    ctl(8'h00);
    idle(50);
  endtask

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    resetn = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = '0;
    wb_sel = 4'hf;
    wb_dat = '0;
    miscompares = 0;
    checks_done = 0;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(OFS_CTRL, rv);
    check("ctrl reset", rv, {24'h0, CTRL_RST});
    check("pump reset", {31'h0, pump_en}, 32'h0);
    ctl(8'h08);
    rd(OFS_CTRL, rv);
    check("hv no mode", rv, 32'h0);
    ctl(8'h03);
    rd(OFS_CTRL, rv);
    check("both set", rv, 32'h0);
    ctl(8'h01);
    ctl(8'h03);
    rd(OFS_CTRL, rv);
    check("pgm kept", rv, 32'h1);
    ctl(8'h00);
    $display("test registers done");
    erase(1'b1, 16'h3456);
    foreach (pa[i])
    begin
      rd(fa(pa[i]), rv);
      check("mass erased", {24'h0, rv[7:0]}, {24'h0, ERASED_BYTE});
    end
    $display("test mass erase done");
    program_all();
    rd(fa(16'h1201), rv);
    check("programmed", {24'h0, rv[7:0]}, 32'ha5);
    $display("test program done");
    erase(1'b0, 16'hfe10);
    foreach (pa[i])
    begin
      rd(fa(pa[i]), rv);
      check("page erase", {24'h0, rv[7:0]}, {24'h0, pe[i]});
    end
    $display("test page erase done");
    ctl(8'h02);
    wr(fa(16'h0200), 32'h0);
    idle(NVS_CYC + 10);
    ctl(8'h0a);
    check("pump before reset", {31'h0, pump_en}, 32'h1);
    resetn <= 1'b0;
    idle(4);
    check("pump in reset", {31'h0, pump_en}, 32'h0);
    resetn <= 1'b1;
    rd(OFS_CTRL, rv);
    check("ctrl after reset", rv, 32'h0);
    rd(OFS_STATUS, rv);
    check("status after reset", rv, 32'h0);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule // tb_fec_top
